// >>> rtl/pds_top.sv
// What this block does
// - enabled sync pin clears the R counter and the single N counter (prescaler, A and B combined) in the same cycle
// - sync-pin counter reset is disabled after reset until software enables it
// - reference and feedback paths each have an enableable 3-bit programmable delay
// - fixed divide mode ignores A; feedback division is prescaler times B
// - B equal to one bypasses A and B; division equals prescaler alone
// - lock indication routes through per-pin muxes to three output pins
// - every phase detector cycle the rising-edge separation is measured
// - lock asserts after a selectable count of consecutive cycles under threshold
// - once locked, one cycle beyond unlock threshold drops lock at once
// - unlock threshold is wider than lock threshold for hysteresis
// - thresholds derive from window bit and backlash width field; count setting picks the lock cycle count
// - reference divider values zero and one both divide by one
//
// Chosen here: the AXI4-Lite register port and the register addresses.
module pds_top
   import pds_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // pll clocks and sync pin
   input  wire logic        refIn,
   input  wire logic        fbIn,
   input  wire logic        syncPin_n,
   // axi4-lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // pins and interrupt
   output      logic        lockDetectPin,
   output      logic        statusPin,
   output      logic        referenceMonitorPin,
   output      logic        digitalLockIndication,
   output      logic        irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   typedef enum logic [1:0] {PD_IDLE, PD_WAIT_FB, PD_WAIT_REF} pds_pdstate_t;

   function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         if (s[i]) old[8*i +: 8] = d[8*i +: 8];
      end
      return old;
   endfunction : applyStrb

   function automatic logic pinDrive(input logic [1:0] sel, input logic lk);
      case (pds_pinsel_t'(sel))
         PM_LOW:    pinDrive = 1'b0;
         PM_LOCK:   pinDrive = lk;
         PM_UNLOCK: pinDrive = ~lk;
         default:   pinDrive = 1'b1;
      endcase
   endfunction : pinDrive

   function automatic logic [18:0] prescVal(input pds_presc_t p);
      case (p)
         PS_DM2:  prescVal = 19'h2;
         PS_DM4:  prescVal = 19'h4;
         PS_DM8:  prescVal = 19'h8;
         PS_DM16: prescVal = 19'h10;
         PS_DM32: prescVal = 19'h20;
         PS_FD1:  prescVal = 19'h1;
         PS_FD2:  prescVal = 19'h2;
         default: prescVal = 19'h3;
      endcase
   endfunction : prescVal

   ////////////////////////////////////////////////////////////////////////////
   logic [31:0]        regRdiv, regNdiv, regSync, regLdcfg, regPinmux, regIrqMsk;
   logic [IRQ_W-1:0]   irqSt;
   logic [7:0]         awAddr;
   logic [31:0]        wData;
   logic [3:0]         wStrb;
   logic               awHeld, wHeld;
   logic               doWrite, doRead, rdIrq;
   logic               lock, lockRise, lockFall;
   logic [7:0]         lockCnt, lastSep;
   pds_ndiv_t          ndiv;
   pds_ldcfg_t         ldcfg;

   assign ndiv  = pds_ndiv_t'({regNdiv[NDIV_P_LSB +: 3], regNdiv[NDIV_A_LSB +: 6],
                               regNdiv[NDIV_B_LSB +: 13]});
   assign ldcfg = pds_ldcfg_t'({regLdcfg[LD_WIN_BIT], regLdcfg[LD_CNT_LSB +: 2],
                                regLdcfg[LD_ABP_LSB +: 2]});

   // axi handshakes
   assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
   assign s_axi_wready  = ~wHeld & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign doWrite = awHeld & wHeld & ~s_axi_bvalid;
   assign doRead  = s_axi_arvalid & s_axi_arready;
   assign rdIrq   = doRead & (s_axi_araddr == OFF_IRQST);

   // write channel capture and response
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 8'h00;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AXI_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (awAddr)
               OFF_RDIV, OFF_NDIV, OFF_SYNC, OFF_LDCFG, OFF_PINMUX, OFF_IRQMSK,
               OFF_STATUS, OFF_IRQST: s_axi_bresp <= AXI_OKAY;
               default:               s_axi_bresp <= AXI_SLVERR;
            endcase
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // configuration registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         regRdiv <= RST_RDIV;
         regNdiv <= RST_NDIV;
         regSync <= RST_SYNC;
         regLdcfg <= RST_LDCFG;
         regPinmux <= RST_PINMUX;
         regIrqMsk <= RST_IRQMSK;
      end else if (doWrite) begin
         case (awAddr)
            OFF_RDIV:   regRdiv <= applyStrb(regRdiv, wData, wStrb) & 32'h0000_3fff;
            OFF_NDIV:   regNdiv <= applyStrb(regNdiv, wData, wStrb) & 32'h073f_1fff;
            OFF_SYNC:   regSync <= applyStrb(regSync, wData, wStrb) & 32'h0000_0fcf;
            OFF_LDCFG:  regLdcfg <= applyStrb(regLdcfg, wData, wStrb) & 32'h0000_0073;
            OFF_PINMUX: regPinmux <= applyStrb(regPinmux, wData, wStrb) & 32'h0000_003f;
            OFF_IRQMSK: regIrqMsk <= applyStrb(regIrqMsk, wData, wStrb) & 32'h0000_0003;
            default: ;
         endcase
      end
   end

   // read channel
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= AXI_OKAY;
      end else if (doRead) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= AXI_OKAY;
         case (s_axi_araddr)
            OFF_RDIV:   s_axi_rdata <= regRdiv;
            OFF_NDIV:   s_axi_rdata <= regNdiv;
            OFF_SYNC:   s_axi_rdata <= regSync;
            OFF_LDCFG:  s_axi_rdata <= regLdcfg;
            OFF_PINMUX: s_axi_rdata <= regPinmux;
            OFF_STATUS: s_axi_rdata <= {8'h00, lastSep, lockCnt, 7'h00, lock};
            OFF_IRQST:  s_axi_rdata <= {30'h0, irqSt};
            OFF_IRQMSK: s_axi_rdata <= regIrqMsk;
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= AXI_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // sticky events, read clears, new event wins
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irqSt <= '0;
      end else begin
         irqSt <= (rdIrq ? '0 : irqSt) | {lockFall, lockRise};
      end
   end
   assign irq = |(irqSt & regIrqMsk[IRQ_W-1:0]);

   ////////////////////////////////////////////////////////////////////////////
   logic        refPrev, fbPrev, refEdge, fbEdge, syncClr;
   logic [13:0] rCnt, rTerm;
   logic [18:0] nCnt, nTotal;
   logic        refDivPulse, fbDivPulse;
   logic [1:0]  syncEnAct;

   assign refEdge = refIn & ~refPrev;
   assign fbEdge  = fbIn & ~fbPrev;
   assign rTerm   = (regRdiv[13:0] <= 14'h1) ? 14'h1 : regRdiv[13:0];
   assign syncClr = (syncEnAct != 2'b00) & ~syncPin_n;

   // feedback division from prescaler, a and b
   always_comb begin
      if (ndiv.bCount <= 13'h1) begin
         nTotal = prescVal(ndiv.presc);
      end else if (ndiv.presc >= PS_FD1) begin
         nTotal = 19'(prescVal(ndiv.presc) * 19'(ndiv.bCount));
      end else begin
         nTotal = 19'(prescVal(ndiv.presc) * 19'(ndiv.bCount) + 19'(ndiv.aCount));
      end
   end

   // r and n counters, both cleared together by sync
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         refPrev <= 1'b0;
         fbPrev <= 1'b0;
         rCnt <= 14'h0;
         nCnt <= 19'h0;
         refDivPulse <= 1'b0;
         fbDivPulse <= 1'b0;
      end else begin
         refPrev <= refIn;
         fbPrev <= fbIn;
         refDivPulse <= 1'b0;
         fbDivPulse <= 1'b0;
         if (syncClr) begin
            rCnt <= 14'h0;
            nCnt <= 19'h0;
         end else begin
            if (refEdge) begin
               refDivPulse <= (rCnt >= rTerm - 14'h1);
               rCnt <= (rCnt >= rTerm - 14'h1) ? 14'h0 : rCnt + 14'h1;
            end
            if (fbEdge) begin
               fbDivPulse <= (nCnt >= nTotal - 19'h1);
               nCnt <= (nCnt >= nTotal - 19'h1) ? 19'h0 : nCnt + 19'h1;
            end
         end
      end
   end

   // sync enable taken at a reference divider output, or at once while disabled
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         syncEnAct <= 2'b00;
      end else if (refDivPulse || syncEnAct == 2'b00) begin
         syncEnAct <= regSync[SYNC_EN_LSB +: 2];
      end
   end

   a_sync_clear: assert property (syncClr |=> rCnt == 14'h0 && nCnt == 19'h0)
      else $error("sync did not clear counters");
   a_sync_off: assert property (syncEnAct == 2'b00 && !syncPin_n && refEdge
                                && rCnt >= rTerm - 14'h1 |=> refDivPulse)
      else $error("disabled sync touched r counter");
   a_bypass_n: assert property (ndiv.bCount == 13'h1 && ndiv.presc == PS_FD1 && fbEdge
                                && !syncClr |=> fbDivPulse)
      else $error("b bypass wrong");
   a_r_one: assert property (regRdiv[13:0] == 14'h0 && refEdge && !syncClr
                             |=> refDivPulse)
      else $error("r zero not divide by one");

   ////////////////////////////////////////////////////////////////////////////
   logic [1:0] dlyIn, dlyOut, dlyEnAct;
   logic [2:0] dlyTap [2];
   logic [7:0] dlyLine [2];
   logic       refPfd, fbPfd;

   assign dlyIn = {fbDivPulse, refDivPulse};

   // programmable delay cells, settings taken at each path's own output
   for (genvar g = 0; g < 2; g++) begin : g_dly
      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            dlyLine[g] <= 8'h00;
            dlyTap[g] <= 3'h0;
            dlyEnAct[g] <= 1'b0;
         end else begin
            dlyLine[g] <= {dlyLine[g][6:0], dlyIn[g]};
            if (dlyIn[g] && dlyLine[g] == 8'h00) begin
               dlyTap[g] <= g ? regSync[FB_DLY_LSB +: 3] : regSync[REF_DLY_LSB +: 3];
               dlyEnAct[g] <= g ? regSync[FB_DLY_EN] : regSync[REF_DLY_EN];
            end
         end
      end
      // the pulse that loads new settings already follows them: none lost or doubled
      assign dlyOut[g] = ((dlyIn[g] && dlyLine[g] == 8'h00)
                          ? (g ? regSync[FB_DLY_EN] : regSync[REF_DLY_EN])
                          : dlyEnAct[g]) ? dlyLine[g][dlyTap[g]] : dlyIn[g];
   end
   assign refPfd = dlyOut[0];
   assign fbPfd  = dlyOut[1];

   a_dly_tap: assert property (refDivPulse && dlyLine[0] == 8'h00 && regSync[REF_DLY_EN]
                               && regSync[REF_DLY_LSB +: 3] == 3'h5 |-> !refPfd ##6 refPfd)
      else $error("reference delay tap wrong");

   ////////////////////////////////////////////////////////////////////////////
   pds_pdstate_t pdState;
   logic [7:0]   sepCnt, lockThr, unlockThr, cntTarget, measSep;
   logic         measValid, measBig;

   assign lockThr   = 8'((LOCK_THR_BASE + 8'(ldcfg.abp)) << ldcfg.win);
   assign unlockThr = 8'(lockThr << 1);
   always_comb begin
      case (ldcfg.cnt)
         2'd0:    cntTarget = LD_CNT_SEL0;
         2'd1:    cntTarget = LD_CNT_SEL1;
         2'd2:    cntTarget = LD_CNT_SEL2;
         default: cntTarget = LD_CNT_SEL3;
      endcase
   end

   // edge separation measurement per phase detector cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pdState <= PD_IDLE;
         sepCnt <= 8'h0;
         measValid <= 1'b0;
         measBig <= 1'b0;
         measSep <= 8'h0;
      end else begin
         measValid <= 1'b0;
         sepCnt <= sepCnt + 8'h1;
         case (pdState)
            PD_IDLE: begin
               sepCnt <= 8'h0;
               if (refPfd && fbPfd) begin
                  measValid <= 1'b1;
                  measBig <= 1'b0;
                  measSep <= 8'h0;
               end else if (refPfd) begin
                  pdState <= PD_WAIT_FB;
               end else if (fbPfd) begin
                  pdState <= PD_WAIT_REF;
               end
            end
            PD_WAIT_FB, PD_WAIT_REF: begin
               if ((pdState == PD_WAIT_FB) ? fbPfd : refPfd) begin
                  measValid <= 1'b1;
                  measBig <= 1'b0;
                  measSep <= sepCnt + 8'h1;
                  pdState <= PD_IDLE;
               end else if ((pdState == PD_WAIT_FB ? refPfd : fbPfd)
                            || sepCnt + 8'h1 > unlockThr) begin
                  measValid <= 1'b1;
                  measBig <= 1'b1;
                  measSep <= sepCnt + 8'h1;
                  pdState <= PD_IDLE;
               end
            end
            default: pdState <= PD_IDLE;
         endcase
      end
   end

   // consecutive-cycle lock counting with unlock hysteresis
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lock <= 1'b0;
         lockCnt <= 8'h0;
         lastSep <= 8'h0;
      end else if (measValid) begin
         lastSep <= measSep;
         if (!lock) begin
            if (!measBig && measSep < lockThr) begin
               if (lockCnt + 8'h1 >= cntTarget) begin
                  lock <= 1'b1;
                  lockCnt <= 8'h0;
               end else begin
                  lockCnt <= lockCnt + 8'h1;
               end
            end else begin
               lockCnt <= 8'h0;
            end
         end else if (measBig || measSep > unlockThr) begin
            lock <= 1'b0;
         end
      end
   end
   assign lockRise = measValid & ~lock & ~measBig & (measSep < lockThr)
                     & (lockCnt + 8'h1 >= cntTarget);
   assign lockFall = measValid & lock & (measBig | (measSep > unlockThr));

   // output pin muxes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lockDetectPin <= 1'b0;
         statusPin <= 1'b0;
         referenceMonitorPin <= 1'b0;
         digitalLockIndication <= 1'b0;
      end else begin
         lockDetectPin <= pinDrive(regPinmux[PM_LD_LSB +: 2], lock);
         statusPin <= pinDrive(regPinmux[PM_ST_LSB +: 2], lock);
         referenceMonitorPin <= pinDrive(regPinmux[PM_RM_LSB +: 2], lock);
         digitalLockIndication <= lock;
      end
   end

   a_meas_same: assert property (pdState == PD_IDLE && refPfd && fbPfd
                                 |=> measValid && measSep == 8'h0 && !measBig)
      else $error("coincident edges not measured as zero");
   a_lock_count: assert property ($rose(lock) |-> $past(measValid)
                                  && $past(lockCnt) + 8'h1 >= $past(cntTarget))
      else $error("lock before count reached");
   a_unlock_now: assert property (lock && measValid && (measBig || measSep > unlockThr)
                                  |=> !lock ##1 !digitalLockIndication)
      else $error("lock not dropped");
   a_hyst_wider: assert property (unlockThr > lockThr)
      else $error("unlock window not wider");
   a_thr_derive: assert property (lockThr == (LOCK_THR_BASE + 8'(ldcfg.abp))
                                  * (ldcfg.win ? 8'd2 : 8'd1))
      else $error("window bit not applied");
   a_cnt_restart: assert property (!lock && measValid && (measBig || measSep >= lockThr)
                                   |=> lockCnt == 8'h0 && !lock)
      else $error("lock count not restarted");
   a_pin_route: assert property (regPinmux[PM_LD_LSB +: 2] == 2'd1
                                 |=> lockDetectPin == $past(lock))
      else $error("lock pin route wrong");
   a_sync_hold: assert property (!refDivPulse && syncEnAct != 2'b00
                                 |=> syncEnAct == $past(syncEnAct))
      else $error("sync enable changed mid period");

   c_lock: cover property ($rose(lock));
   c_unlock: cover property ($fell(lock));
   c_sync: cover property (syncClr ##1 !syncClr ##[1:100] refDivPulse);
   c_irq: cover property ($rose(irq));
endmodule : pds_top

// >>> shared/pds_pkg.sv
package pds_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_RDIV   = 8'h00;
   localparam logic [7:0] OFF_NDIV   = 8'h04;
   localparam logic [7:0] OFF_SYNC   = 8'h08;
   localparam logic [7:0] OFF_LDCFG  = 8'h0c;
   localparam logic [7:0] OFF_PINMUX = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_IRQST  = 8'h18;
   localparam logic [7:0] OFF_IRQMSK = 8'h1c;
   // reset values
   localparam logic [31:0] RST_RDIV   = 32'h0000_0000;
   localparam logic [31:0] RST_NDIV   = 32'h0000_0001;
   localparam logic [31:0] RST_SYNC   = 32'h0000_0000;
   localparam logic [31:0] RST_LDCFG  = 32'h0000_0000;
   localparam logic [31:0] RST_PINMUX = 32'h0000_0000;
   localparam logic [31:0] RST_IRQMSK = 32'h0000_0000;
   // field positions
   localparam int NDIV_B_LSB   = 0;
   localparam int NDIV_A_LSB   = 16;
   localparam int NDIV_P_LSB   = 24;
   localparam int SYNC_EN_LSB  = 6;
   localparam int REF_DLY_LSB  = 0;
   localparam int REF_DLY_EN   = 3;
   localparam int FB_DLY_LSB   = 8;
   localparam int FB_DLY_EN    = 11;
   localparam int LD_ABP_LSB   = 0;
   localparam int LD_WIN_BIT   = 4;
   localparam int LD_CNT_LSB   = 5;
   localparam int PM_LD_LSB    = 0;
   localparam int PM_ST_LSB    = 2;
   localparam int PM_RM_LSB    = 4;
   localparam int IRQ_LOCK     = 0;
   localparam int IRQ_UNLOCK   = 1;
   localparam int IRQ_W        = 2;
   // timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int DELAY_SPAN_NS = 1;
   localparam int DELAY_STEP_CYC = (DELAY_SPAN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] LOCK_THR_BASE = 8'h02;
   localparam logic [7:0] LD_CNT_SEL0   = 8'h05;
   localparam logic [7:0] LD_CNT_SEL1   = 8'h10;
   localparam logic [7:0] LD_CNT_SEL2   = 8'h40;
   localparam logic [7:0] LD_CNT_SEL3   = 8'hff;
   localparam logic [1:0] AXI_OKAY   = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;

   typedef enum logic [2:0] {PS_DM2, PS_DM4, PS_DM8, PS_DM16, PS_DM32,
                             PS_FD1, PS_FD2, PS_FD3} pds_presc_t;
   typedef enum logic [1:0] {PM_LOW, PM_LOCK, PM_UNLOCK, PM_HIGH} pds_pinsel_t;

   typedef struct packed {
      pds_presc_t  presc;
      logic [5:0]  aCount;
      logic [12:0] bCount;
   } pds_ndiv_t;

   typedef struct packed {
      logic       win;
      logic [1:0] cnt;
      logic [1:0] abp;
   } pds_ldcfg_t;
endpackage : pds_pkg

// >>> tb/pds_clk_src.sv
module pds_clk_src
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       arst_n,
   // control
   input  wire logic       en,
   input  wire logic [7:0] lag,
   // pll clocks
   output      logic       refIn,
   output      logic       fbIn
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PER = 40; // period well above unlock threshold
   logic [7:0] phase;
   logic [7:0] fbPhase;
   ////////////////////////////////////////
   // feedback trails reference by lag cycles
   assign fbPhase = (phase + 8'(PER) - lag) % 8'(PER);
   // both clocks stand still low while disabled
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase <= 8'h00;
         refIn <= 1'b0;
         fbIn  <= 1'b0;
      end else if (en) begin
         phase <= (phase == 8'(PER - 1)) ? 8'h00 : phase + 8'h01;
         refIn <= phase < 8'(PER / 2);
         fbIn  <= fbPhase < 8'(PER / 2);
      end else begin
         refIn <= 1'b0;
         fbIn  <= 1'b0;
      end
   end
endmodule : pds_clk_src

// >>> tb/pll_divider_sync_lock_detect_bench.sv
module pll_divider_sync_lock_detect_bench
   import pds_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, arst_n, syncPin_n, en;
   logic [7:0]  lag, awAddr, arAddr;
   logic [31:0] wData, rData, d;
   logic [3:0]  wStrb;
   logic        awValid, awReady, wValid, wReady, bValid, bReady;
   logic        arValid, arReady, rValid, rReady;
   logic [1:0]  bResp, rResp, r;
   logic        refIn, fbIn, ldPin, stPin, rmPin, dli, irq;
   int          error_cnt, n_compared;
   logic [7:0]  offs [6] = '{OFF_RDIV, OFF_NDIV, OFF_SYNC, OFF_LDCFG, OFF_PINMUX, OFF_IRQMSK};
   logic [31:0] rsts [6] = '{RST_RDIV, RST_NDIV, RST_SYNC, RST_LDCFG, RST_PINMUX, RST_IRQMSK};
   ////////////////////////////////////////
   pds_top pds_top_inst (.clk(clk), .arst_n(arst_n), .refIn(refIn), .fbIn(fbIn),
      .syncPin_n(syncPin_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
      .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
      .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
      .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
      .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .lockDetectPin(ldPin), .statusPin(stPin), .referenceMonitorPin(rmPin),
      .digitalLockIndication(dli), .irq(irq));
   pds_clk_src pds_clk_src_inst (.clk(clk), .arst_n(arst_n), .en(en), .lag(lag),
      .refIn(refIn), .fbIn(fbIn));
   ////////////////////////////////////////
   // clock and watchdog
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      $display("CHECK FAILED watchdog expected done seen hang");
      report_and_stop();
   end
   ////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // axi4-lite write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      logic awDone;
      logic wDone;
      awAddr  <= a;
      wData   <= v;
      wStrb   <= 4'hf;
      awValid <= 1'b1;
      wValid  <= 1'b1;
      awDone = 1'b0;
      wDone = 1'b0;
      while (!(awDone && wDone)) begin
         @(posedge clk);
         if (!awDone && awReady === 1'b1) begin
            awDone = 1'b1;
            awValid <= 1'b0;
         end
         if (!wDone && wReady === 1'b1) begin
            wDone = 1'b1;
            wValid <= 1'b0;
         end
      end
      bReady <= 1'b1;
      do @(posedge clk); while (bValid !== 1'b1);
      resp = bResp;
      bReady <= 1'b0;
   endtask : wr
   // axi4-lite read
   task automatic rd(input logic [7:0] a, output logic [31:0] data, output logic [1:0] resp);
      arAddr  <= a;
      arValid <= 1'b1;
      do @(posedge clk); while (arReady !== 1'b1);
      arValid <= 1'b0;
      rReady  <= 1'b1;
      do @(posedge clk); while (rValid !== 1'b1);
      data = rData;
      resp = rResp;
      rReady <= 1'b0;
   endtask : rd
   // lock reaches v within n cycles, or holds v for all n when stay is set
   task automatic dliIs(input logic v, input int n, input bit stay);
      logic ok;
      ok = stay;
      repeat (n) begin
         @(posedge clk);
         if (stay && dli !== v) ok = 1'b0;
         if (!stay && dli === v) ok = 1'b1;
      end
      chk("lock indication", 32'h1, 32'(ok));
   endtask : dliIs
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////
   // main sequence
   initial begin
      {arst_n, syncPin_n, en, lag, awAddr, arAddr, wData, wStrb} = '0;
      {awValid, wValid, bReady, arValid, rReady} = '0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         rd(offs[i], d, r);
         chk("reset value", rsts[i], d);
         chk("rresp", 32'(AXI_OKAY), 32'(r));
      end
      rd(8'h20, d, r);
      chk("unmapped rresp", 32'(AXI_SLVERR), 32'(r));
      wr(8'h24, 32'h1, r);
      chk("unmapped bresp", 32'(AXI_SLVERR), 32'(r));
      // five cycles to lock, lock window 4, unlock window 8
      wr(OFF_LDCFG, 32'h2, r);
      chk("bresp", 32'(AXI_OKAY), 32'(r));
      wr(OFF_PINMUX, 32'h39, r);
      wr(OFF_IRQMSK, 32'h3, r);
      // fixed divide by one, a five ignored, b one
      wr(OFF_NDIV, {5'h0, PS_FD1, 24'h05_0001}, r);
      en <= 1'b1;
      dliIs(1'b0, 120, 1'b1);
      dliIs(1'b1, 400, 1'b0);
      chk("pins", 32'h5, {29'h0, ldPin, stPin, rmPin});
      rd(OFF_STATUS, d, r);
      chk("status", 32'h1, d);
      chk("irq raised", 32'h1, 32'(irq));
      rd(OFF_IRQST, d, r);
      chk("lock event", 32'h1, d);
      chk("irq cleared", 32'h0, 32'(irq));
      wr(OFF_RDIV, 32'h1, r);
      dliIs(1'b1, 200, 1'b1);
      lag <= 8'd14;
      dliIs(1'b0, 80, 1'b0);
      chk("pins unlocked", 32'h3, {29'h0, ldPin, stPin, rmPin});
      chk("irq unlock", 32'h1, 32'(irq));
      rd(OFF_IRQST, d, r);
      chk("unlock event", 32'h2, d);
      chk("irq cleared again", 32'h0, 32'(irq));
      lag <= 8'd6;
      dliIs(1'b0, 400, 1'b1);
      // reference delay of six cycles realigns the edges
      wr(OFF_SYNC, 32'hd, r);
      dliIs(1'b1, 600, 1'b0);
      wr(OFF_SYNC, 32'h0, r);
      dliIs(1'b1, 400, 1'b1);
      lag <= 8'd0;
      repeat (80) @(posedge clk);
      // sync held low while enabled freezes the dividers
      wr(OFF_SYNC, 32'hc0, r);
      repeat (80) @(posedge clk);
      lag <= 8'd14;
      dliIs(1'b1, 300, 1'b1);
      syncPin_n <= 1'b1;
      dliIs(1'b0, 200, 1'b0);
      report_and_stop();
   end
endmodule : pll_divider_sync_lock_detect_bench
